/* rtl/xfer_test_wait_core.sv */
// execution core for register transfer, test and wait instructions
`timescale 1ns/1ps
// What this block does
// RULE1 - opcode 97 copies the accumulator into the index register, flags kept, in two cycles.
// RULE2 - a test subtracts zero from its operand, stores nothing and changes only the N and Z flags.
// RULE3 - test opcodes 3D, 4D, 5D, 6D, 7D are direct, accumulator, index, byte-offset and plain indexed, 4/3/3/5/4 cycles.
// RULE4 - opcode 9F copies the index register into the accumulator, flags kept, in two cycles.
// RULE5 - opcode 8F clears the interrupt mask and then halts the core clock, listed at two cycles.
// RULE6 - after a wait the core resumes and starts interrupt processing on an unmasked interrupt or reset; reset here gives no O_IRQ_TAKE pulse.
module xfer_test_wait_core
(
  input  wire logic       I_CLK_SYS,     // 40 MHz core clock
  input  wire logic       I_RESET,       // async reset, active high
  input  wire logic       I_OP_VALID,    // opcode byte present
  input  wire logic [7:0] I_OPCODE,      // opcode byte
  input  wire logic [7:0] I_OFFSET,      // direct address or index offset byte
  input  wire logic [7:0] I_MEM_RDATA,   // data memory read data
  input  wire logic       I_IRQ,         // interrupt request level, from a pin
  output logic            O_BUSY,        // instruction in progress
  output logic            O_DONE,        // one-cycle pulse at instruction end
  output logic            O_ILLEGAL,     // pulse: opcode not in this group
  output logic            O_MEM_RD,      // data memory read strobe
  output logic      [7:0] O_MEM_ADDR,    // data memory address
  output logic      [7:0] O_ACC,         // accumulator
  output logic      [7:0] O_INDEX,       // index register
  output logic      [4:0] O_FLAGS,       // condition flags register H I N Z C
  output logic            O_CLK_HALTED,  // core clock stopped by wait
  output logic            O_IRQ_TAKE     // pulse: begin interrupt processing
);
  // state machine
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_EXEC = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_WAKE = 4'b1000
  } state_t;

  state_t                        state_reg;
  state_t                        state_next;
  xfer_test_wait_pkg::op_kind_t  kind_dec;
  xfer_test_wait_pkg::test_src_t src_dec;
  logic                    [2:0] cycles_dec;
  logic                          has_off_dec;
  xfer_test_wait_pkg::op_kind_t  kind_reg;
  xfer_test_wait_pkg::test_src_t src_reg;
  logic                    [2:0] count_reg;
  logic                    [7:0] acc_reg;
  logic                    [7:0] index_reg;
  logic                    [4:0] flags_reg;
  logic                          irq_meta_reg;
  logic                          irq_sync_reg;
  logic                          busy_reg;
  logic                          done_reg;
  logic                          illegal_reg;
  logic                          mem_rd_reg;
  logic                    [7:0] mem_addr_reg;
  logic                          halted_reg;
  logic                          irq_take_reg;
  logic                          last_cycle;
  logic                    [7:0] test_value;
  logic                    [7:0] test_diff;

  op_decoder u_dec
  (
    .i_opcode     (I_OPCODE),
    .o_kind       (kind_dec),
    .o_src        (src_dec),
    .o_cycles     (cycles_dec),
    .o_has_offset (has_off_dec)
  );

  // two-stage sync of the external interrupt level
  always_ff @(posedge I_CLK_SYS or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      irq_meta_reg <= 1'b0;
      irq_sync_reg <= 1'b0;
    end
    else
    begin
      irq_meta_reg <= I_IRQ;
      irq_sync_reg <= irq_meta_reg;
    end
  end

  // count reaches one in the final cycle of an instruction
  assign last_cycle = (state_reg == ST_EXEC) && (count_reg == 3'h1);

  // test operand: memory data arrives in the last cycle
  always_comb
  begin
    unique case (src_reg)
      xfer_test_wait_pkg::SRC_ACC:   test_value = acc_reg;
      xfer_test_wait_pkg::SRC_INDEX: test_value = index_reg;
      default:                       test_value = I_MEM_RDATA;
    endcase
    test_diff = test_value - xfer_test_wait_pkg::TEST_SUBTRAHEND;   // [RULE2]
  end

  // sequencing
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:
      begin
        if (I_OP_VALID && kind_dec != xfer_test_wait_pkg::OPK_NONE)
          state_next = ST_EXEC;
      end
      ST_EXEC:
      begin
        if (count_reg == 3'h1)
          state_next = (kind_reg == xfer_test_wait_pkg::OPK_WAIT) ? ST_WAIT : ST_IDLE;
      end
      ST_WAIT:
      begin
        // mask was cleared on entry, so any request wakes the core
        if (irq_sync_reg && !flags_reg[xfer_test_wait_pkg::FLAG_I])
          state_next = ST_WAKE;                                      // [RULE6]
      end
      ST_WAKE:
      begin
        state_next = ST_IDLE;
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RESET)
  begin
    if (I_RESET)
      state_reg <= ST_IDLE;                                          // [RULE6]
    else
      state_reg <= state_next;
  end

  // latch the decoded instruction; opcode cycle counts as the first
  always_ff @(posedge I_CLK_SYS or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      kind_reg  <= xfer_test_wait_pkg::OPK_NONE;
      src_reg   <= xfer_test_wait_pkg::SRC_ACC;
      count_reg <= 3'h0;
    end
    else if (state_reg == ST_IDLE && I_OP_VALID && kind_dec != xfer_test_wait_pkg::OPK_NONE)
    begin
      kind_reg  <= kind_dec;
      src_reg   <= src_dec;
      count_reg <= cycles_dec - 3'h1;                          // [RULE1] [RULE3] [RULE4] [RULE5]
    end
    else if (state_reg == ST_EXEC && count_reg != 3'h0)
    begin
      count_reg <= count_reg - 3'h1;
    end
  end

  // memory operand address; held through the instruction
  always_ff @(posedge I_CLK_SYS or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      mem_addr_reg <= 8'h00;
      mem_rd_reg   <= 1'b0;
    end
    else if (state_reg == ST_IDLE && I_OP_VALID && kind_dec == xfer_test_wait_pkg::OPK_TEST
             && src_dec == xfer_test_wait_pkg::SRC_MEM)
    begin
      unique case (I_OPCODE)
        xfer_test_wait_pkg::OP_TEST_DIRECT:   mem_addr_reg <= I_OFFSET;                  // [RULE3]
        xfer_test_wait_pkg::OP_TEST_IDX_BYTE: mem_addr_reg <= index_reg + I_OFFSET;      // [RULE3]
        default:                              mem_addr_reg <= index_reg;                 // [RULE3]
      endcase
      mem_rd_reg <= 1'b1;
    end
    else if (last_cycle)
    begin
      mem_rd_reg <= 1'b0;
    end
  end

  // register transfers; flags untouched here
  always_ff @(posedge I_CLK_SYS or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      acc_reg   <= xfer_test_wait_pkg::ACC_RESET;
      index_reg <= xfer_test_wait_pkg::INDEX_RESET;
    end
    else if (last_cycle && kind_reg == xfer_test_wait_pkg::OPK_ACC_TO_IDX)
    begin
      index_reg <= acc_reg;                                          // [RULE1]
    end
    else if (last_cycle && kind_reg == xfer_test_wait_pkg::OPK_IDX_TO_ACC)
    begin
      acc_reg <= index_reg;                                          // [RULE4]
    end
  end

  // condition flags: only test and wait alter them
  always_ff @(posedge I_CLK_SYS or posedge I_RESET)
  begin
    if (I_RESET)
      flags_reg <= xfer_test_wait_pkg::FLAGS_RESET;
    else if (last_cycle && kind_reg == xfer_test_wait_pkg::OPK_TEST)
    begin
      flags_reg[xfer_test_wait_pkg::FLAG_N] <= test_diff[7];         // [RULE2]
      flags_reg[xfer_test_wait_pkg::FLAG_Z] <= (test_diff == 8'h00); // [RULE2]
    end
    else if (state_reg == ST_IDLE && I_OP_VALID && kind_dec == xfer_test_wait_pkg::OPK_WAIT)
    begin
      // mask cleared before the clock halts
      flags_reg[xfer_test_wait_pkg::FLAG_I] <= 1'b0;                 // [RULE5]
    end
  end

  // status outputs, all registered
  always_ff @(posedge I_CLK_SYS or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      busy_reg     <= 1'b0;
      done_reg     <= 1'b0;
      illegal_reg  <= 1'b0;
      halted_reg   <= 1'b0;
      irq_take_reg <= 1'b0;
    end
    else
    begin
      busy_reg     <= (state_next != ST_IDLE);
      done_reg     <= last_cycle;
      illegal_reg  <= (state_reg == ST_IDLE) && I_OP_VALID && (kind_dec == xfer_test_wait_pkg::OPK_NONE);
      halted_reg   <= (state_next == ST_WAIT);                       // [RULE5]
      irq_take_reg <= (state_reg == ST_WAIT) && (state_next == ST_WAKE); // [RULE6]
    end
  end

  assign O_BUSY       = busy_reg;
  assign O_DONE       = done_reg;
  assign O_ILLEGAL    = illegal_reg;
  assign O_MEM_RD     = mem_rd_reg;
  assign O_MEM_ADDR   = mem_addr_reg;
  assign O_ACC        = acc_reg;
  assign O_INDEX      = index_reg;
  assign O_FLAGS      = flags_reg;
  assign O_CLK_HALTED = halted_reg;
  assign O_IRQ_TAKE   = irq_take_reg;
endmodule

/* inc/xfer_test_wait_pkg.sv */
// constants for the transfer, test and wait instruction group
package xfer_test_wait_pkg;
  localparam logic [7:0] OP_COPY_ACC_TO_INDEX = 8'h97;
  localparam logic [7:0] OP_COPY_INDEX_TO_ACC = 8'h9F;
  localparam logic [7:0] OP_WAIT              = 8'h8F;
  localparam logic [7:0] OP_TEST_DIRECT       = 8'h3D;
  localparam logic [7:0] OP_TEST_ACC          = 8'h4D;
  localparam logic [7:0] OP_TEST_INDEX        = 8'h5D;
  localparam logic [7:0] OP_TEST_IDX_BYTE     = 8'h6D;
  localparam logic [7:0] OP_TEST_IDX_NONE     = 8'h7D;
  localparam logic [7:0] TEST_SUBTRAHEND      = 8'h00;
  // cycle counts per form
  localparam logic [2:0] CYC_TRANSFER         = 3'h2;
  localparam logic [2:0] CYC_WAIT             = 3'h2;
  localparam logic [2:0] CYC_TEST_DIRECT      = 3'h4;
  localparam logic [2:0] CYC_TEST_ACC         = 3'h3;
  localparam logic [2:0] CYC_TEST_INDEX       = 3'h3;
  localparam logic [2:0] CYC_TEST_IDX_BYTE    = 3'h5;
  localparam logic [2:0] CYC_TEST_IDX_NONE    = 3'h4;
  // flag positions in the condition flags register (H I N Z C)
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_I = 3;
  localparam int FLAG_H = 4;
  localparam logic [4:0] FLAGS_RESET = 5'h08;
  localparam logic [7:0] ACC_RESET   = 8'h00;
  localparam logic [7:0] INDEX_RESET = 8'h00;
  // operation classes
  typedef enum logic [3:0] {
    OPK_NONE = 4'h0,
    OPK_ACC_TO_IDX = 4'h1,
    OPK_IDX_TO_ACC = 4'h2,
    OPK_WAIT       = 4'h3,
    OPK_TEST       = 4'h4
  } op_kind_t;
  // operand source of the test
  typedef enum logic [2:0] {
    SRC_ACC   = 3'h0,
    SRC_INDEX = 3'h1,
    SRC_MEM   = 3'h2
  } test_src_t;
endpackage

/* rtl/op_decoder.sv */
// combinational opcode decoder for the instruction group
`timescale 1ns/1ps
module op_decoder
(
  input  wire logic [7:0]                    i_opcode,    // fetched opcode
  output xfer_test_wait_pkg::op_kind_t       o_kind,      // operation class
  output xfer_test_wait_pkg::test_src_t      o_src,       // test operand source
  output logic      [2:0]                    o_cycles,    // total cycles
  output logic                               o_has_offset // one offset byte follows
);
  // map opcode to class, source and length
  always_comb
  begin
    o_kind       = xfer_test_wait_pkg::OPK_NONE;
    o_src        = xfer_test_wait_pkg::SRC_ACC;
    o_cycles     = 3'h1;
    o_has_offset = 1'b0;
    unique case (i_opcode)
      xfer_test_wait_pkg::OP_COPY_ACC_TO_INDEX:
      begin
        o_kind   = xfer_test_wait_pkg::OPK_ACC_TO_IDX;     // [RULE1]
        o_cycles = xfer_test_wait_pkg::CYC_TRANSFER;
      end
      xfer_test_wait_pkg::OP_COPY_INDEX_TO_ACC:
      begin
        o_kind   = xfer_test_wait_pkg::OPK_IDX_TO_ACC;     // [RULE4]
        o_cycles = xfer_test_wait_pkg::CYC_TRANSFER;
      end
      xfer_test_wait_pkg::OP_WAIT:
      begin
        o_kind   = xfer_test_wait_pkg::OPK_WAIT;           // [RULE5]
        o_cycles = xfer_test_wait_pkg::CYC_WAIT;
      end
      xfer_test_wait_pkg::OP_TEST_DIRECT:
      begin
        o_kind       = xfer_test_wait_pkg::OPK_TEST;       // [RULE3]
        o_src        = xfer_test_wait_pkg::SRC_MEM;
        o_cycles     = xfer_test_wait_pkg::CYC_TEST_DIRECT;
        o_has_offset = 1'b1;
      end
      xfer_test_wait_pkg::OP_TEST_ACC:
      begin
        o_kind   = xfer_test_wait_pkg::OPK_TEST;           // [RULE3]
        o_cycles = xfer_test_wait_pkg::CYC_TEST_ACC;
      end
      xfer_test_wait_pkg::OP_TEST_INDEX:
      begin
        o_kind   = xfer_test_wait_pkg::OPK_TEST;           // [RULE3]
        o_src    = xfer_test_wait_pkg::SRC_INDEX;
        o_cycles = xfer_test_wait_pkg::CYC_TEST_INDEX;
      end
      xfer_test_wait_pkg::OP_TEST_IDX_BYTE:
      begin
        o_kind       = xfer_test_wait_pkg::OPK_TEST;       // [RULE3]
        o_src        = xfer_test_wait_pkg::SRC_MEM;
        o_cycles     = xfer_test_wait_pkg::CYC_TEST_IDX_BYTE;
        o_has_offset = 1'b1;
      end
      xfer_test_wait_pkg::OP_TEST_IDX_NONE:
      begin
        o_kind   = xfer_test_wait_pkg::OPK_TEST;           // [RULE3]
        o_src    = xfer_test_wait_pkg::SRC_MEM;
        o_cycles = xfer_test_wait_pkg::CYC_TEST_IDX_NONE;
      end
      default:
      begin
        o_kind = xfer_test_wait_pkg::OPK_NONE;             // outside this group
      end
    endcase
  end
endmodule

/* dv/xfer_test_wait_props.sv */
// assertions on the ports of the transfer, test and wait core
`timescale 1ns/1ps
module xfer_test_wait_props
(
  input wire logic       I_CLK_SYS,    // core clock
  input wire logic       I_RESET,      // async reset
  input wire logic       I_OP_VALID,   // opcode present
  input wire logic [7:0] I_OPCODE,     // opcode byte
  input wire logic [7:0] I_OFFSET,     // offset byte
  input wire logic [7:0] I_MEM_RDATA,  // memory data
  input wire logic       I_IRQ,        // interrupt level
  input wire logic       O_BUSY,       // in progress
  input wire logic       O_DONE,       // end pulse
  input wire logic       O_ILLEGAL,    // unknown opcode
  input wire logic       O_MEM_RD,     // read strobe
  input wire logic [7:0] O_MEM_ADDR,   // read address
  input wire logic [7:0] O_ACC,        // accumulator
  input wire logic [7:0] O_INDEX,      // index register
  input wire logic [4:0] O_FLAGS,      // H I N Z C
  input wire logic       O_CLK_HALTED, // waiting
  input wire logic       O_IRQ_TAKE    // wake pulse
);
  logic idle;
  // an opcode is taken only when neither busy nor halted
  assign idle = !O_BUSY && !O_CLK_HALTED && I_OP_VALID;
  default clocking @(posedge I_CLK_SYS);
  endclocking
  default disable iff (I_RESET);
  // done of an N-cycle op is sampled N edges after the take edge
  a_acc_to_index: assert property (idle && I_OPCODE == 8'h97 |-> ##2 (O_DONE && O_INDEX == $past(O_ACC, 2)
    && O_FLAGS == $past(O_FLAGS, 2))) else $error("copy to index wrong");
  a_index_to_acc: assert property (idle && I_OPCODE == 8'h9F |-> ##2 (O_DONE && O_ACC == $past(O_INDEX, 2)
    && O_FLAGS == $past(O_FLAGS, 2))) else $error("copy to accumulator wrong");
  // H, I and C must survive a test, hence the 5'h19 mask
  a_test_acc: assert property (idle && I_OPCODE == 8'h4D |-> ##3 (O_DONE && O_ACC == $past(O_ACC, 3)
    && O_FLAGS[2] == ($past(O_ACC, 3) >= 8'h80) && O_FLAGS[1] == ($past(O_ACC, 3) == 8'h00)
    && (O_FLAGS & 5'h19) == ($past(O_FLAGS, 3) & 5'h19))) else $error("accumulator test flags wrong");
  a_test_mem: assert property (idle && I_OPCODE == 8'h3D |-> ##4 (O_FLAGS[2] == ($past(I_MEM_RDATA) >= 8'h80)
    && O_FLAGS[1] == ($past(I_MEM_RDATA) == 8'h00))) else $error("memory test flags wrong");
  a_busy_span: assert property (idle && I_OPCODE == 8'h6D |=> O_BUSY [*4] ##1 (!O_BUSY && O_DONE))
    else $error("offset test length wrong");
  a_mem_addr: assert property (idle && I_OPCODE == 8'h6D |=> O_MEM_RD
    && O_MEM_ADDR == 8'($past(O_INDEX) + $past(I_OFFSET))) else $error("offset address wrong");
  a_illegal_only: assert property (idle && !(I_OPCODE inside {8'h97, 8'h9F, 8'h8F, 8'h3D, 8'h4D, 8'h5D,
    8'h6D, 8'h7D}) |=> O_ILLEGAL && !O_BUSY) else $error("unknown opcode not refused");
  a_wait_mask: assert property (idle && I_OPCODE == 8'h8F |=> !O_FLAGS[3] ##1 O_CLK_HALTED)
    else $error("wait did not unmask and halt");
  a_wake_irq: assert property (O_CLK_HALTED && I_IRQ && !O_FLAGS[3] |-> ##[1:6] O_IRQ_TAKE)
    else $error("no wake on interrupt");
endmodule
bind xfer_test_wait_core xfer_test_wait_props i_xfer_test_wait_props (.I_CLK_SYS(I_CLK_SYS), .I_RESET(I_RESET),
  .I_OP_VALID(I_OP_VALID), .I_OPCODE(I_OPCODE), .I_OFFSET(I_OFFSET), .I_MEM_RDATA(I_MEM_RDATA), .I_IRQ(I_IRQ),
  .O_BUSY(O_BUSY), .O_DONE(O_DONE), .O_ILLEGAL(O_ILLEGAL), .O_MEM_RD(O_MEM_RD), .O_MEM_ADDR(O_MEM_ADDR),
  .O_ACC(O_ACC), .O_INDEX(O_INDEX), .O_FLAGS(O_FLAGS), .O_CLK_HALTED(O_CLK_HALTED), .O_IRQ_TAKE(O_IRQ_TAKE));

/* dv/tb.sv */
// self-checking bench for the transfer, test and wait core
`timescale 1ns/1ps
module tb;
  logic       I_CLK_SYS, I_RESET, I_OP_VALID, I_IRQ;
  logic [7:0] I_OPCODE, I_OFFSET, I_MEM_RDATA;
  logic       O_BUSY, O_DONE, O_ILLEGAL, O_MEM_RD, O_CLK_HALTED, O_IRQ_TAKE;
  logic [7:0] O_MEM_ADDR, O_ACC, O_INDEX;
  logic [4:0] O_FLAGS;
  int         n_errors;
  int         compares;
  xfer_test_wait_core i_xfer_test_wait_core (.I_CLK_SYS(I_CLK_SYS), .I_RESET(I_RESET), .I_OP_VALID(I_OP_VALID),
    .I_OPCODE(I_OPCODE), .I_OFFSET(I_OFFSET), .I_MEM_RDATA(I_MEM_RDATA), .I_IRQ(I_IRQ), .O_BUSY(O_BUSY),
    .O_DONE(O_DONE), .O_ILLEGAL(O_ILLEGAL), .O_MEM_RD(O_MEM_RD), .O_MEM_ADDR(O_MEM_ADDR), .O_ACC(O_ACC),
    .O_INDEX(O_INDEX), .O_FLAGS(O_FLAGS), .O_CLK_HALTED(O_CLK_HALTED), .O_IRQ_TAKE(O_IRQ_TAKE));
  // 25 ns period
  always #12.5 I_CLK_SYS = ~I_CLK_SYS;
  // four-state compare so an unknown never matches
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one opcode; cyc of 0 means it must be refused
  task automatic run_op(input logic [7:0] op, off, mem, flg, adr, input int cyc, input logic rd);
    int n;
    @(posedge I_CLK_SYS);
    I_OP_VALID  <= 1'b1;
    I_OPCODE    <= op;
    I_OFFSET    <= off;
    I_MEM_RDATA <= mem;
    @(posedge I_CLK_SYS);
    I_OP_VALID  <= 1'b0;
    #1;
    check(8'(O_ILLEGAL), 8'(cyc == 0), "refusal");
    check(8'(O_BUSY), 8'(cyc != 0), "busy after take");
    check(8'(O_MEM_RD), 8'(rd), "read strobe");
    if (rd)
      check(O_MEM_ADDR, adr, "address");
    // opcode cycle counts as the first, so the edge after the take ends the second
    for (n = 2; n <= 9 && cyc != 0; n++)
    begin
      @(posedge I_CLK_SYS);
      #1;
      if (O_DONE === 1'b1)
        break;
    end
    if (cyc != 0)
      check(8'(n), 8'(cyc), "cycle count");
    check(8'(O_BUSY), 8'h00, "idle at end");
    check(8'(O_FLAGS), 8'(flg), "flags");
    check(O_ACC, 8'h00, "accumulator");
    check(O_INDEX, 8'h00, "index");
    $display("test done: opcode %h", op);
    if (n > 9)
      print_verdict();
  endtask
  // halt, then wake by interrupt or by reset
  task automatic wait_wake(input logic by_reset);
    int n;
    @(posedge I_CLK_SYS);
    I_OP_VALID <= 1'b1;
    I_OPCODE   <= 8'h8F;
    @(posedge I_CLK_SYS);
    I_OPCODE   <= 8'h97;
    repeat (4) @(posedge I_CLK_SYS);
    #1;
    check(8'(O_CLK_HALTED), 8'h01, "halted");
    check(8'(O_FLAGS), 8'h00, "mask cleared");
    check(8'(O_DONE), 8'h00, "opcode ignored while halted");
    I_OP_VALID <= 1'b0;
    if (by_reset)
    begin
      @(posedge I_CLK_SYS);
      I_RESET <= 1'b1;
      @(posedge I_CLK_SYS);
      I_RESET <= 1'b0;
    end
    else
    begin
      I_IRQ <= 1'b1;
      for (n = 0; n < 8; n++)
      begin
        @(posedge I_CLK_SYS);
        #1;
        if (O_IRQ_TAKE === 1'b1)
          break;
      end
      check(8'(n < 8), 8'h01, "wake pulse");
      I_IRQ <= 1'b0;
      if (n == 8)
        print_verdict();
    end
    @(posedge I_CLK_SYS);
    #1;
    check(8'(O_CLK_HALTED), 8'h00, "resumed");
    check(8'(O_FLAGS), by_reset ? 8'h08 : 8'h00, "flags after wake");
    $display("test done: wait, reset wake %0d", by_reset);
  endtask
  initial
  begin
    I_CLK_SYS   = 1'b0;
    I_RESET     = 1'b1;
    I_OP_VALID  = 1'b0;
    I_IRQ       = 1'b0;
    I_OPCODE    = 8'h00;
    I_OFFSET    = 8'h00;
    I_MEM_RDATA = 8'h00;
    n_errors    = 0;
    compares    = 0;
    repeat (2) @(posedge I_CLK_SYS);
    I_RESET <= 1'b0;
    #1;
    check(8'(O_FLAGS), 8'h08, "reset flags");
    check(8'(O_BUSY), 8'h00, "reset busy");
    // flags stay with I set through transfers
    run_op(8'h97, 8'h00, 8'h80, 8'h08, 8'h00, 2, 1'b0);
    run_op(8'h9F, 8'h00, 8'h80, 8'h08, 8'h00, 2, 1'b0);
    wait_wake(1'b0);
    // each test form with its own length and operand
    run_op(8'h3D, 8'h5A, 8'h80, 8'h04, 8'h5A, 4, 1'b1);
    run_op(8'h4D, 8'h00, 8'h80, 8'h02, 8'h00, 3, 1'b0);
    run_op(8'h5D, 8'h00, 8'h80, 8'h02, 8'h00, 3, 1'b0);
    run_op(8'h6D, 8'hF0, 8'h00, 8'h02, 8'hF0, 5, 1'b1);
    run_op(8'h7D, 8'h33, 8'h7F, 8'h00, 8'h00, 4, 1'b1);
    run_op(8'h9D, 8'h00, 8'h00, 8'h00, 8'h00, 0, 1'b0);
    wait_wake(1'b1);
    print_verdict();
  end
endmodule
